/* File: pkg/led_gate_pkg.sv */
// constants, field layouts and state types shared by both link ends
package led_gate_pkg;
  // ****************************************
  // general
  // ****************************************
  localparam int          CHANNELS        = 16;
  localparam int          PCLK_HZ         = 50_000_000;
  localparam int          SCL_PERIOD_NS   = 10_000;
  localparam int          PCLK_PERIOD_NS  = 1_000_000_000 / PCLK_HZ;
  localparam int          QUARTER_CYCLES  = SCL_PERIOD_NS / (4 * PCLK_PERIOD_NS);
  localparam logic [7:0]  GC_ADDR_BYTE    = 8'h00;
  localparam logic [7:0]  RESET_DATA_BYTE = 8'h06;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // ****************************************
  // output configuration register layout
  // ****************************************
  localparam int          CFG_LEVEL_LSB   = 0;
  localparam int          CFG_TOTEM_BIT   = 2;
  localparam int          CFG_INVERT_BIT  = 3;
  localparam logic [3:0]  CFG_RESET       = 4'h4;
  localparam logic [1:0]  LEVEL_LOW       = 2'h0;
  localparam logic [1:0]  LEVEL_HIGH      = 2'h1;

  // ****************************************
  // controller apb map
  // ****************************************
  localparam logic [7:0]  ADDR_BYTE_OFS   = 8'h00;
  localparam logic [7:0]  DATA_BYTE_OFS   = 8'h04;
  localparam logic [7:0]  CTRL_OFS        = 8'h08;
  localparam logic [7:0]  STATUS_OFS      = 8'h0c;
  localparam logic [7:0]  ADDR_BYTE_RESET = 8'h00;
  localparam logic [7:0]  DATA_BYTE_RESET = 8'h06;
  localparam logic [1:0]  NBYTES_RESET    = 2'h1;
  localparam int          CTRL_GO_BIT     = 0;
  localparam int          CTRL_NBYTES_LSB = 4;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_DONE_BIT   = 1;
  localparam int          STAT_ABORT_BIT  = 2;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE     = 6'b000001,
    S_ADDR     = 6'b000010,
    S_ADDR_ACK = 6'b000100,
    S_DATA     = 6'b001000,
    S_DATA_ACK = 6'b010000,
    S_ARMED    = 6'b100000
  } slave_state_e;

  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_FREE  = 6'b000010,
    H_START = 6'b000100,
    H_BYTE  = 6'b001000,
    H_STOP  = 6'b010000,
    H_SKIP  = 6'b100000
  } master_state_e;
endpackage : led_gate_pkg

/* File: pkg/i2c_link_if.sv */
// two-wire serial link between the reset-call controller and the led device
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl;
  logic sda;
  // controller drive
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  // device drive
  logic s_sda_o;
  logic s_sda_oe;

  // open drain with pull-ups: any enabled driver pulls its line low
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
                  output m_sda_o, output m_sda_oe);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : i2c_link_if
`default_nettype wire

/* File: src/gate_stage.sv */
// output gate: pwm state, inversion and disabled level per channel
`timescale 1ns/1ps
`default_nettype none
module gate_stage import led_gate_pkg::*; #(
  parameter int N = CHANNELS
) (
  // gate pin and settings
  input  wire logic         oe_n,
  input  wire logic [N-1:0] pwm_state,
  input  wire logic         polarity_invert,
  input  wire logic         totem_pole_select,
  input  wire logic [1:0]   disabled_output_level,
  // channel pins
  output logic      [N-1:0] led_out,
  output logic      [N-1:0] led_oe
);
  logic [N-1:0] level;

  // no clock on this path so an external gate waveform dims at once
  always_comb begin  // R21
    level = pwm_state ^ {N{polarity_invert}};  // R02 R04
    if (!oe_n) begin  // R01
      led_out = level;  // R02
      // open drain only sinks; a high level floats
      led_oe  = {N{totem_pole_select}} | ~level;
    end else begin
      led_out = {N{disabled_output_level == LEVEL_HIGH}};  // R03 R04
      unique case (disabled_output_level)
        LEVEL_LOW:  led_oe = {N{1'b1}};  // R03
        LEVEL_HIGH: led_oe = {N{totem_pole_select}};  // R03
        default:    led_oe = {N{1'b0}};  // R03
      endcase
    end
  end
endmodule : gate_stage
`default_nettype wire

/* File: src/led_device.sv */
// led device end: output gating, power-on reset and bus reset call slave
// How it works
// [R01] gate pin switches all sixteen outputs together
// [R02] gate low: outputs follow pwm, optional inversion
// [R03] gate high: disabled-level field sets every output
// [R04] inversion acts only while gate is low
// [R05] power-on reset loads registers and bus defaults
// [R06] master sends start then all-zero write address
// [R07] acknowledge only general call address byte 00h
// [R08] all-zero address with read bit: no acknowledge
// [R09] first data byte acknowledged only when 06h
// [R10] no acknowledge for later data bytes
// [R11] stop after 06h resets registers, addressable again
// [R12] malformed reset call never resets registers
// [R13] master treats any missing acknowledge as abort
// [R14] master starts only with both lines high
// [R15] data stays stable while clock is high
// [R16] start and stop are data edges, clock high
// [R17] ninth clock carries acknowledge, receiver pulls low
// [R18] addressed receiver acknowledges each received byte; the device acknowledges only the address byte and a first data byte of 06h
// [R19] reading master leaves last byte unacknowledged
// [R20] unacknowledged transmitter releases data line high
// [R21] gate pin acts without waiting for a clock
`timescale 1ns/1ps
`default_nettype none
module led_device import led_gate_pkg::*; #(
  parameter int N = CHANNELS
) (
  // clock and power-on reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // serial link
  i2c_link_if.slave         link,
  // gate pin and pwm core
  input  wire logic         oe_n,
  input  wire logic [N-1:0] pwm_state,
  // output configuration access from the register core
  input  wire logic         cfg_we,
  input  wire logic [3:0]   cfg_wdata,
  output logic      [3:0]   cfg_rdata,
  output logic              bus_reset_pulse,
  // channel pins
  output logic      [N-1:0] led_out,
  output logic      [N-1:0] led_oe
);
  // ****************************************
  // line synchronisers
  // ****************************************
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= link.scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;  // R16
  assign stop_det  = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;  // R16 R15
  assign scl_rise  = scl_s_r && !scl_d_r;
  assign scl_fall  = !scl_s_r && scl_d_r;

  // ****************************************
  // reset call receiver
  // ****************************************
  slave_state_e state_r;
  logic [3:0]   bit_cnt_r;
  logic [7:0]   shift_r;
  logic         ack_oe_r;
  logic         match;

  // address phase takes 00h only, so a read bit fails the compare
  assign match = (state_r == S_ADDR) ? (shift_r == GC_ADDR_BYTE)  // R07 R08
                                     : (shift_r == RESET_DATA_BYTE);  // R09

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin  // R05
      state_r   <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ack_oe_r  <= 1'b0;
    end else if (start_det) begin
      // a repeated start also drops an armed call
      state_r   <= S_ADDR;  // R12
      bit_cnt_r <= 4'h0;
      ack_oe_r  <= 1'b0;
    end else if (stop_det) begin
      state_r   <= S_IDLE;  // R11
      ack_oe_r  <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
        end
        S_ADDR, S_DATA: begin
          if (scl_rise && bit_cnt_r < BITS_PER_BYTE) begin
            shift_r   <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            bit_cnt_r <= 4'h0;
            if (match) begin
              ack_oe_r <= 1'b1;  // R17 R18
              state_r  <= (state_r == S_ADDR) ? S_ADDR_ACK : S_DATA_ACK;
            end else begin
              state_r  <= S_IDLE;  // R08 R09 R12
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            ack_oe_r <= 1'b0;  // R20
            state_r  <= S_DATA;
          end
        end
        S_DATA_ACK: begin
          if (scl_fall) begin
            ack_oe_r <= 1'b0;  // R20
            state_r  <= S_ARMED;
          end
        end
        S_ARMED: begin
          // the stop clock also rises here, so only a completed low-going
          // clock marks another byte: call is malformed, left unanswered
          if (scl_fall) begin
            state_r <= S_IDLE;  // R10 R12
          end
        end
      endcase
    end
  end

  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = ack_oe_r;  // R17

  // ****************************************
  // reset pulse to the register core
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reset_pulse <= 1'b0;
    end else begin
      bus_reset_pulse <= stop_det && !start_det && (state_r == S_ARMED);  // R11 R12
    end
  end

  // ****************************************
  // output configuration register
  // ****************************************
  logic [3:0] cfg_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;  // R05
    end else if (bus_reset_pulse) begin
      // reset call wins over a write in the same cycle
      cfg_r <= CFG_RESET;  // R11
    end else if (cfg_we) begin
      cfg_r <= cfg_wdata;
    end
  end

  assign cfg_rdata = cfg_r;

  // ****************************************
  // output gate
  // ****************************************
  gate_stage #(.N(N)) u_gate (
    .oe_n                  (oe_n),
    .pwm_state             (pwm_state),
    .polarity_invert       (cfg_r[CFG_INVERT_BIT]),
    .totem_pole_select     (cfg_r[CFG_TOTEM_BIT]),
    .disabled_output_level (cfg_r[CFG_LEVEL_LSB +: 2]),
    .led_out               (led_out),
    .led_oe                (led_oe)
  );  // R01 R21
endmodule : led_device
`default_nettype wire

/* File: src/reset_call_master.sv */
// controller end: apb-programmed bus master that issues the reset call
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reset_call_master import led_gate_pkg::*; #(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  i2c_link_if.master       link
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] addr_byte_r, data_byte_r;
  logic [1:0] nbytes_r;
  logic       done_r, abort_r, go, wr, mapped, finish, nack_seen;
  master_state_e st_r;

  assign wr     = psel && penable && pwrite;
  assign mapped = paddr inside {ADDR_BYTE_OFS, DATA_BYTE_OFS, CTRL_OFS, STATUS_OFS};
  assign go     = wr && paddr == CTRL_OFS && pwdata[CTRL_GO_BIT] && st_r == H_IDLE;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_byte_r <= ADDR_BYTE_RESET;
      data_byte_r <= DATA_BYTE_RESET;
      nbytes_r    <= NBYTES_RESET;
    end else if (wr) begin
      if (paddr == ADDR_BYTE_OFS) addr_byte_r <= pwdata[7:0];
      if (paddr == DATA_BYTE_OFS) data_byte_r <= pwdata[7:0];
      if (paddr == CTRL_OFS) nbytes_r <= pwdata[CTRL_NBYTES_LSB +: 2];
    end
  end

  // hardware set wins over the clear done by a new go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r  <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      if (finish) done_r <= 1'b1;
      else if (go) done_r <= 1'b0;
      if (nack_seen) abort_r <= 1'b1;  // R13
      else if (go) abort_r <= 1'b0;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel) begin
      unique case (paddr)
        ADDR_BYTE_OFS: prdata[7:0] = addr_byte_r;
        DATA_BYTE_OFS: prdata[7:0] = data_byte_r;
        CTRL_OFS:      prdata[CTRL_NBYTES_LSB +: 2] = nbytes_r;
        STATUS_OFS: begin
          prdata[STAT_BUSY_BIT]  = st_r != H_IDLE;
          prdata[STAT_DONE_BIT]  = done_r;
          prdata[STAT_ABORT_BIT] = abort_r;
        end
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // line sync and quarter-bit divider
  // ****************************************
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, tick;
  logic [15:0] div_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= link.scl;
      scl_s_r <= scl_m_r;
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
    end else if (tick || st_r == H_IDLE) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = div_r == 16'(QUARTER - 1);

  // ****************************************
  // bit sequencer
  // ****************************************
  logic [1:0] q_r, sent_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic       scl_low_r, sda_low_r, ack_bad_r;

  assign finish    = tick && st_r == H_STOP && q_r == 2'h3;
  assign nack_seen = tick && st_r == H_BYTE && q_r == 2'h3
                     && bit_r == BITS_PER_BYTE && ack_bad_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= H_IDLE;
      q_r       <= 2'h0;
      bit_r     <= 4'h0;
      sent_r    <= 2'h0;
      tx_r      <= 8'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      ack_bad_r <= 1'b0;
    end else if (go) begin
      st_r <= H_FREE;
      q_r  <= 2'h0;
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      unique case (st_r)
        H_IDLE, H_SKIP: begin
          q_r <= 2'h0;
        end
        H_FREE: begin
          q_r <= 2'h0;
          if (scl_s_r && sda_s_r) st_r <= H_START;  // R14
        end
        H_START: begin
          if (q_r == 2'h1) sda_low_r <= 1'b1;  // R06 R16
          if (q_r == 2'h2) scl_low_r <= 1'b1;
          if (q_r == 2'h3) begin
            st_r   <= H_BYTE;
            bit_r  <= 4'h0;
            sent_r <= 2'h0;
            tx_r   <= addr_byte_r;  // R06
          end
        end
        H_BYTE: begin
          unique case (q_r)
            // data only moves while the clock is low
            2'h0: sda_low_r <= (bit_r < BITS_PER_BYTE) && !tx_r[7];  // R15 R17 R19
            2'h1: scl_low_r <= 1'b0;
            2'h2: ack_bad_r <= sda_s_r;
            2'h3: begin
              scl_low_r <= 1'b1;
              if (bit_r < BITS_PER_BYTE) begin
                tx_r  <= {tx_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
              end else if (ack_bad_r || sent_r == nbytes_r) begin
                st_r <= H_STOP;  // R13
              end else begin
                sent_r <= sent_r + 2'h1;
                tx_r   <= data_byte_r;
                bit_r  <= 4'h0;
              end
            end
          endcase
        end
        H_STOP: begin
          if (q_r == 2'h0) sda_low_r <= 1'b1;
          if (q_r == 2'h1) scl_low_r <= 1'b0;
          if (q_r == 2'h2) sda_low_r <= 1'b0;  // R11 R16
          if (q_r == 2'h3) st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = scl_low_r;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_low_r;
endmodule : reset_call_master
`default_nettype wire

/* File: tb/led_gate_assertions.sv */
// concurrent checks on the link wires and the gated led pins
`timescale 1ns/1ps
`default_nettype none
module led_gate_assertions import led_gate_pkg::*; (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link wires
  input wire logic        scl,
  input wire logic        sda,
  input wire logic        s_sda_oe,
  // device pins
  input wire logic        oe_n,
  input wire logic [15:0] pwm_state,
  input wire logic [3:0]  cfg_rdata,
  input wire logic        bus_reset_pulse,
  input wire logic [15:0] led_out,
  input wire logic [15:0] led_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // sequences and checks
  // ****************************************
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  sequence ack_s; s_sda_oe && $rose(scl); endsequence
  a_gate_follow: assert property (
    !oe_n |-> led_out == (pwm_state ^ {16{cfg_rdata[3]}})
    && led_oe == (cfg_rdata[2] ? 16'hffff : ~led_out))
    else $error("gate low output mismatch");
  a_level_low: assert property (
    oe_n && cfg_rdata[1:0] == LEVEL_LOW |-> led_out == 16'h0 && led_oe == 16'hffff)
    else $error("disabled level low mismatch");
  a_level_high: assert property (
    oe_n && cfg_rdata[1:0] == LEVEL_HIGH |-> led_out == 16'hffff && led_oe == {16{cfg_rdata[2]}})
    else $error("disabled level high mismatch");
  a_level_float: assert property (
    oe_n && cfg_rdata[1] |-> led_oe == 16'h0)
    else $error("disabled level float mismatch");
  a_ack_held: assert property (
    ack_s |-> (!sda)[*4])
    else $error("acknowledge not held low");
  a_slave_stable: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device data moved with clock high");
  a_no_slave_cond: assert property (
    (start_s or stop_s) |-> !s_sda_oe)
    else $error("device formed a bus condition");
  a_pulse_restores: assert property (
    bus_reset_pulse |=> !bus_reset_pulse && cfg_rdata == CFG_RESET)
    else $error("reset pulse or restore wrong");
  a_pulse_after_stop: assert property (
    bus_reset_pulse |-> scl && sda && !$past(sda, 4))
    else $error("reset pulse without stop");
endmodule : led_gate_assertions
`default_nettype wire

/* File: tb/led_output_gate_and_bus_reset_tb_top.sv */
// bench: controller sends reset calls over the link to the led device
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module led_output_gate_and_bus_reset_tb_top import led_gate_pkg::*; ;
  // short quarter bit keeps the run brief
  localparam int Q = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        oe_n = 1, cfg_we = 0, bus_reset_pulse, look = 0, noted = 0;
  logic [7:0]  paddr = '0, x;
  logic [31:0] pwdata = '0, prdata, r;
  logic [15:0] pwm_state = '0, led_out, led_oe, p;
  logic [3:0]  cfg_wdata = '0, cfg_rdata;
  logic [32:0] rq[$], re;
  logic [35:0] gq[$], ge;
  int          miscompares = 0, cmp_count = 0, seed = 81870, scl_n = 0;
  always #10 pclk = ~pclk;
  i2c_link_if link ();
  reset_call_master #(.QUARTER(Q)) i_reset_call_master (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  led_device i_led_device (.pclk(pclk), .presetn(presetn), .link(link), .oe_n(oe_n),
    .pwm_state(pwm_state), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .bus_reset_pulse(bus_reset_pulse), .led_out(led_out), .led_oe(led_oe));
  led_gate_assertions i_led_gate_assertions (.pclk(pclk), .presetn(presetn),
    .scl(link.scl), .sda(link.sda), .s_sda_oe(link.s_sda_oe), .oe_n(oe_n),
    .pwm_state(pwm_state), .cfg_rdata(cfg_rdata), .bus_reset_pulse(bus_reset_pulse),
    .led_out(led_out), .led_oe(led_oe));
  always @(posedge link.scl) scl_n++;
  // ****************************************
  // monitors and tasks
  // ****************************************
  always @(posedge pclk) if (psel && penable && pready && noted) begin
    re = rq.pop_front();
    `CMP({pslverr, pwrite ? 32'h0 : prdata}, re)
  end
  always @(look) if (gq.size() > 0) begin
    ge = gq.pop_front();
    `CMP({cfg_rdata, led_oe, led_out}, ge)
  end
  function automatic logic [31:0] gate_exp(input logic [3:0] c, input logic o,
                                           input logic [15:0] v);
    logic [15:0] q;
    q = v ^ {16{c[3]}};
    if (!o) return {c[2] ? 16'hffff : ~q, q};
    if (c[1]) return 32'h0;
    if (c[0]) return {{16{c[2]}}, 16'hffff};
    return {16'hffff, 16'h0};
  endfunction : gate_exp
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic nt, input logic [32:0] e, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    noted <= nt;
    if (nt) rq.push_back(e);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // the 1 ns pause shows the gate acting without a clock edge
  task automatic peek(input logic o, input logic [15:0] v, input logic [35:0] e);
    @(posedge pclk);
    oe_n <= o;
    pwm_state <= v;
    #1;
    gq.push_back(e);
    look = ~look;
  endtask : peek
  task automatic cfg_set(input logic [3:0] v);
    @(posedge pclk);
    cfg_we <= 1;
    cfg_wdata <= v;
    @(posedge pclk);
    cfg_we <= 0;
  endtask : cfg_set
  task automatic defaults(input string t);
    presetn <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    peek(1, 0, {CFG_RESET, gate_exp(CFG_RESET, 1, 0)});
    apb(ADDR_BYTE_OFS, 0, 0, 1, {25'h0, ADDR_BYTE_RESET}, r);
    apb(DATA_BYTE_OFS, 0, 0, 1, {25'h0, DATA_BYTE_RESET}, r);
    apb(CTRL_OFS, 0, 0, 1, {27'h0, NBYTES_RESET, 4'h0}, r);
    apb(STATUS_OFS, 0, 0, 1, 33'h0, r);
    apb(8'h10, 0, 0, 1, {1'b1, 32'h0}, r);
    apb(8'h14, 1, 32'hffff_ffff, 1, {1'b1, 32'h0}, r);
    $display("test %s done", t);
  endtask : defaults
  task automatic call(input logic [7:0] a, d, input logic [1:0] nb, input logic ab, rst,
                      input int by);
    logic [3:0] c;
    c = rst ? CFG_RESET : 4'hb;
    cfg_set(4'hb);
    apb(ADDR_BYTE_OFS, 1, {24'h0, a}, 1, 33'h0, r);
    apb(DATA_BYTE_OFS, 1, {24'h0, d}, 1, 33'h0, r);
    `CMP({link.scl, link.sda}, 2'b11)
    scl_n = 0;
    apb(CTRL_OFS, 1, {26'h0, nb, 4'h1}, 1, 33'h0, r);
    do apb(STATUS_OFS, 0, 32'h0, 0, 33'h0, r);
    while (r[STAT_DONE_BIT] !== 1'b1);
    // device pulse trails the stop by a few clocks
    repeat (6) @(posedge pclk);
    apb(STATUS_OFS, 0, 32'h0, 1, {30'h0, ab, 2'b10}, r);
    `CMP({link.scl, link.sda}, 2'b11)
    `CMP(scl_n, 9 * by + 1)
    peek(1, 0, {c, gate_exp(c, 1, 0)});
  endtask : call
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // tests
  // ****************************************
  initial begin
    defaults("power on");
    for (int c = 0; c < 16; c++) begin
      cfg_set(4'(c));
      for (int o = 0; o < 2; o++) begin
        p = 16'($random(seed));
        peek(1'(o), p, {4'(c), gate_exp(4'(c), 1'(o), p)});
      end
    end
    $display("test gate done");
    call(8'h00, 8'h06, 2'h1, 0, 1, 2);
    call(8'h01, 8'h06, 2'h1, 1, 0, 1);
    x = 8'($random(seed));
    if (x == 8'h06) x = 8'h07;
    call(8'h00, x, 2'h1, 1, 0, 2);
    call(8'h00, 8'h06, 2'h2, 1, 0, 3);
    call(8'h00, 8'h06, 2'h0, 0, 0, 1);
    x = 8'($random(seed)) | 8'h02;
    call(x, 8'h06, 2'h1, 1, 0, 1);
    call(8'h00, 8'h06, 2'h1, 0, 1, 2);
    $display("test calls done");
    cfg_set(4'hb);
    defaults("second reset");
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule : led_output_gate_and_bus_reset_tb_top
`default_nettype wire
